/* logic/qbp_defines.vh */
// Constants for the quasi-bidirectional ports one and two
`ifndef QBP_DEFINES_VH
`define QBP_DEFINES_VH
`define QBP_PORT_W 8
`define QBP_LATCH_RST 8'hff
`define QBP_BIT_TRIG 5
`define QBP_BIT_CLK 6
`define QBP_CC_N 5
`define QBP_SYNC_RST 8'h00
`endif

/* logic/qbp_clk_div.v */
// Divide-by-two stage for the oscillator input clock
`timescale 1ns/1ps
`default_nettype none
module qbp_clk_div (
    // Clock and reset
    input wire sys_clk,
    input wire rst,
    // Divided clock phase
    output reg clk_half_q
);
    // Toggle each edge so internal timing ignores input duty cycle
    always @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            clk_half_q <= 1'b0;
        end else begin
            clk_half_q <= ~clk_half_q;
        end
    end
endmodule // qbp_clk_div
`default_nettype wire

/* logic/qbp_ports.v */
// Quasi-bidirectional port one and port two pin logic
`timescale 1ns/1ps
`default_nettype none
`include "qbp_defines.vh"
module qbp_ports #(
    parameter W = `QBP_PORT_W
) (
    // Clock and reset
    input wire sys_clk,
    input wire rst,
    // Port one core side
    input wire [W-1:0] first_port_latch,
    input wire verify_mode,
    input wire [W-1:0] verify_addr_low,
    input wire [`QBP_CC_N-1:0] cmp_out,
    input wire [`QBP_CC_N-1:0] cmp_en,
    // Port two core side
    input wire [W-1:0] second_port_latch,
    input wire ext_prog_fetch,
    input wire ext_data_wide_pointer_access,
    input wire ext_data_short_pointer_access,
    input wire [W-1:0] addr_high,
    // Port one pins
    input wire [W-1:0] p1_pin_in,
    output reg [W-1:0] p1_pin_out,
    output reg [W-1:0] p1_pin_oe_n,
    output reg [W-1:0] p1_strong_up,
    // Port two pins
    input wire [W-1:0] p2_pin_in,
    output reg [W-1:0] p2_pin_out,
    output reg [W-1:0] p2_pin_oe_n,
    output reg [W-1:0] p2_strong_up,
    // Synchronised pin levels
    output reg [W-1:0] p1_read_q,
    output reg [W-1:0] p2_read_q,
    // Alternate inputs
    output reg ext_irq_three_in,
    output reg ext_irq_four_in,
    output reg ext_irq_five_in,
    output reg ext_irq_six_in,
    output reg ext_irq_two_in,
    output reg [`QBP_CC_N-1:0] capture_in,
    output reg timer_two_reload_trigger,
    // Divided clock phase
    output reg clk_phase_q
);
    // Pin encoding used on both ports:
    //   pin_out    value the pad shows while it is driven
    //   pin_oe_n   low while the pad is driven (a zero, or a strong one)
    //   strong_up  high while a one is pushed up hard instead of weakly
    // A released pad (oe_n high) rests at the weak pull-up level, so
    // outside logic may pull it low and the pad then serves as an input.
    // An alternate input only reads its pad while the latch bit holds a
    // one; with a zero in the latch and no compare or verify drive the device holds the pad low.

    // Port one bit use:
    //   bits 0-4  interrupt input, compare output, capture input
    //   bit 5     timer two reload trigger input
    //   bit 6     divided system clock output
    //   bit 7     plain I/O only
    // Port two carries the high address byte on external fetches and
    // wide pointer data accesses while no short pointer access is raised,
    // and its own latch at all other times.
    // Verify mode takes over every source on port one.

    // Pin synchronisers, two flops per pad
    reg [W-1:0] p1_s1_q;
    reg [W-1:0] p1_s2_q;
    reg [W-1:0] p2_s1_q;
    reg [W-1:0] p2_s2_q;
    // Next pin values and strong drive masks
    reg [W-1:0] p1_val_d;
    reg [W-1:0] p1_strong_d;
    reg [W-1:0] p2_val_d;
    reg [W-1:0] p2_strong_d;
    // Per-bit helpers from the generate loop
    wire [`QBP_CC_N-1:0] p1_cmp_mux;
    wire [W-1:0] p1_gated;
    // Divided clock and port two address select
    wire clk_half;
    wire p2_addr_mode;
    genvar g;

    // Divide-by-two stage; the divided phase sets internal timing, so the
    // duty cycle of the oscillator input has no effect on it
    qbp_clk_div qbp_clk_div_inst (
        .sys_clk(sys_clk),
        .rst(rst),
        .clk_half_q(clk_half)
    );

    // High address only on fetches and wide pointer accesses; a short
    // pointer access keeps the latch on the pads even if both are raised
    assign p2_addr_mode = (ext_prog_fetch | ext_data_wide_pointer_access)
        & ~ext_data_short_pointer_access;

    // Per-bit logic: latch-gated pin reads, and on bits 0-4 the compare
    // override, which bypasses the latch so compares run with a zero in it
    generate
        for (g = 0; g < W; g = g + 1) begin : g_bit
            assign p1_gated[g] = p1_s2_q[g] & first_port_latch[g];
            if (g < `QBP_CC_N) begin : g_cmp
                assign p1_cmp_mux[g] = cmp_en[g] ? cmp_out[g] : first_port_latch[g];
            end
        end
    endgenerate

    // Port one output value: verify address over compare, clock and latch
    always @* begin
        p1_val_d = first_port_latch;
        p1_strong_d = {W{1'b0}};
        p1_val_d[`QBP_CC_N-1:0] = p1_cmp_mux;
        // Clock output only with a one in latch bit 6, else the pad stays low
        p1_val_d[`QBP_BIT_CLK] = first_port_latch[`QBP_BIT_CLK] & clk_half;
        if (verify_mode) begin
            // Address ones are pushed up hard so the reader sees clean levels
            p1_val_d = verify_addr_low;
            p1_strong_d = verify_addr_low;
        end
    end

    // Port two value; latch unless address phase. While address bits are
    // out every pad is driven and the ones are strong; once the access
    // ends the latch goes back onto the pads, and the latch itself is
    // never written by the address path
    always @* begin
        if (p2_addr_mode) begin
            // Address byte, ones strong
            p2_val_d = addr_high;
            p2_strong_d = addr_high;
        end else begin
            // Latch byte, ones weak
            p2_val_d = second_port_latch;
            p2_strong_d = {W{1'b0}};
        end
    end

    // Pin drivers: a zero pulls low, a one is weak unless strong.
    // Reset leaves every pad released at its weak pull-up, as a latch
    // of all ones would on every pad but the bit 6 clock output
    always @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            // All pads released, nothing strong
            p1_pin_out <= {W{1'b1}};
            p1_pin_oe_n <= {W{1'b1}};
            p1_strong_up <= {W{1'b0}};
            p2_pin_out <= {W{1'b1}};
            p2_pin_oe_n <= {W{1'b1}};
            p2_strong_up <= {W{1'b0}};
            clk_phase_q <= 1'b0;
        end else begin
            p1_pin_out <= p1_val_d;
            p1_pin_oe_n <= p1_val_d & ~p1_strong_d;
            p1_strong_up <= p1_strong_d;
            p2_pin_out <= p2_val_d;
            p2_pin_oe_n <= p2_val_d & ~p2_strong_d;
            p2_strong_up <= p2_strong_d;
            clk_phase_q <= clk_half;
        end
    end

    // Two-stage synchronisers on pin inputs; the pads are asynchronous,
    // so only the second flop of each pair is read by the logic below
    always @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            // Both stages start at zero
            p1_s1_q <= `QBP_SYNC_RST;
            p1_s2_q <= `QBP_SYNC_RST;
            p2_s1_q <= `QBP_SYNC_RST;
            p2_s2_q <= `QBP_SYNC_RST;
        end else begin
            p1_s1_q <= p1_pin_in;
            p1_s2_q <= p1_s1_q;
            p2_s1_q <= p2_pin_in;
            p2_s2_q <= p2_s1_q;
        end
    end

    // Read back ungated, alternate inputs gated by latch one; both lag the
    // pad by three clock edges
    always @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            // Reads and alternate inputs start at zero
            p1_read_q <= `QBP_SYNC_RST;
            p2_read_q <= `QBP_SYNC_RST;
            ext_irq_three_in <= 1'b0;
            ext_irq_four_in <= 1'b0;
            ext_irq_five_in <= 1'b0;
            ext_irq_six_in <= 1'b0;
            ext_irq_two_in <= 1'b0;
            capture_in <= {`QBP_CC_N{1'b0}};
            timer_two_reload_trigger <= 1'b0;
        end else begin
            p1_read_q <= p1_s2_q;
            p2_read_q <= p2_s2_q;
            // Bits 0-3 feed interrupts three to six, bit 4 interrupt two
            ext_irq_three_in <= p1_gated[0];
            ext_irq_four_in <= p1_gated[1];
            ext_irq_five_in <= p1_gated[2];
            ext_irq_six_in <= p1_gated[3];
            ext_irq_two_in <= p1_gated[4];
            // Bits 0-4 also feed the capture channels
            capture_in <= p1_gated[`QBP_CC_N-1:0];
            // Bit 5 is the timer two reload trigger
            timer_two_reload_trigger <= p1_gated[`QBP_BIT_TRIG];
        end
    end

    // Limitations: compare and clock outputs leave a one weak, as the
    // latch does, so a heavy load can hold such a pad low and the read
    // back will show it. Verify mode overrides every other port one source.
endmodule // qbp_ports
`default_nettype wire

/* bench/qbp_ports_props.sv */
// Checker for the port one and port two pin logic
`timescale 1ns/1ps
`default_nettype none
module qbp_ports_props #(parameter int W = 8) (
    // Core side and pins
    input wire logic sys_clk, rst, verify_mode, ext_prog_fetch, ext_data_wide_pointer_access,
    input wire logic ext_data_short_pointer_access,
    input wire logic [W-1:0] first_port_latch, second_port_latch, verify_addr_low, addr_high,
    input wire logic [4:0] cmp_out, cmp_en,
    input wire logic [W-1:0] p1_pin_out, p1_pin_oe_n, p2_pin_out, p2_pin_oe_n, p2_strong_up,
    input wire logic clk_phase_q
);
    default clocking @(posedge sys_clk); endclocking
    default disable iff (rst);
    // Port two carries address bits
    wire adr = (ext_prog_fetch | ext_data_wide_pointer_access) & ~ext_data_short_pointer_access;
    weak_one_a: assert property (!verify_mode && cmp_en == 0 |=>
        (p1_pin_oe_n | 8'h40) == ($past(first_port_latch) | 8'h40)) else $error("weak");
    verify_addr_a: assert property (verify_mode |=> p1_pin_out == $past(verify_addr_low))
        else $error("verify");
    verify_drive_a: assert property (verify_mode |=> p1_pin_oe_n == 0) else $error("vd");
    cmp_pass_a: assert property (cmp_en[0] && !verify_mode |=>
        p1_pin_out[0] == $past(cmp_out[0])) else $error("compare");
    clk_half_a: assert property (!$past(rst) && !$past(rst, 2) |->
        clk_phase_q != $past(clk_phase_q)) else $error("phase");
    p2_latch_a: assert property (!adr |=>
        p2_pin_out == $past(second_port_latch) && p2_strong_up == 0) else $error("latch");
    p2_addr_a: assert property (adr |=> p2_pin_out == $past(addr_high)
        && p2_strong_up == $past(addr_high)) else $error("address");
    p2_drive_a: assert property (adr |=> p2_pin_oe_n == 0) else $error("p2 drive");
    // Main scenarios reached
    cover property (verify_mode);
    cover property (adr ##1 !adr);
    cover property (cmp_en != 0);
endmodule // qbp_ports_props
`default_nettype wire

/* bench/qbp_pin_env.sv */
// Pin model for both ports: weak pull-ups that outside sources may pull low
`timescale 1ns/1ps
`default_nettype none
module qbp_pin_env (
    input wire logic [7:0] p1_pin_out, p1_pin_oe_n, p1_low, p2_pin_out, p2_pin_oe_n, p2_low,
    output logic [7:0] p1_pin_in, p2_pin_in
);
    // Driven bits follow the device, released bits read high unless pulled low
    assign p1_pin_in = (~p1_pin_oe_n & p1_pin_out) | (p1_pin_oe_n & ~p1_low);
    assign p2_pin_in = (~p2_pin_oe_n & p2_pin_out) | (p2_pin_oe_n & ~p2_low);
endmodule // qbp_pin_env
`default_nettype wire

/* bench/qbp_ports_tb.sv */
// Self-checking bench for ports one and two
`timescale 1ns/1ps
`default_nettype none
`define CK(n, e, s) begin cmp_count++; if ((s) !== (e)) begin err_total++; \
    $display("mismatch %s exp %h got %h", n, e, s); end end
module qbp_ports_tb;
    // Core side inputs, outside pull-downs and device outputs
    logic sys_clk = 0, rst = 1, verify_mode = 0, ext_prog_fetch = 0;
    logic ext_data_wide_pointer_access = 0, ext_data_short_pointer_access = 0;
    logic [7:0] first_port_latch = 8'hff, second_port_latch = 8'hff, verify_addr_low = 0;
    logic [7:0] addr_high = 0, p1_low = 0, p2_low = 0, p1_pin_in, p2_pin_in, p1_read_q, p2_read_q;
    logic [7:0] p1_pin_out, p1_pin_oe_n, p1_strong_up, p2_pin_out, p2_pin_oe_n, p2_strong_up;
    logic [4:0] cmp_out = 0, cmp_en = 0, capture_in;
    logic ext_irq_three_in, ext_irq_four_in, ext_irq_five_in, ext_irq_six_in, ext_irq_two_in;
    logic timer_two_reload_trigger, clk_phase_q;
    int err_total = 0, cmp_count = 0;
    always #5 sys_clk = ~sys_clk;
    qbp_ports qbp_ports_inst (.*);
    qbp_pin_env qbp_pin_env_inst (.*);
    // Wait n edges, then step off the edge
    task automatic step(input int n);
        repeat (n) @(posedge sys_clk);
        #1;
    endtask
    // Port one: weak ones, verify address, compare, alternate inputs gated by the latch
    task automatic t_p1();
        first_port_latch = 8'ha5; step(1);
        `CK("p1 weak", 8'ha5, p1_pin_in)
        verify_mode = 1; verify_addr_low = 8'h3c; p1_low = 8'hff; step(1);
        `CK("verify", 8'h3c, p1_pin_in)
        `CK("verify strong", 8'h3c, p1_strong_up)
        verify_mode = 0; first_port_latch = 8'h00; cmp_en = 5'h1f; cmp_out = 5'h15; step(1);
        `CK("compare", 5'h15, p1_pin_out[4:0])
        cmp_en = 0; first_port_latch = 8'hff; p1_low = 8'h05; step(5);
        `CK("capture", 5'h1a, capture_in)
        `CK("irq bit0", 1'b0, ext_irq_three_in)
        `CK("irq bit4", 1'b1, ext_irq_two_in)
        `CK("trigger", 1'b1, timer_two_reload_trigger)
        `CK("irq bit1", 1'b1, ext_irq_four_in)
        `CK("irq bit2", 1'b0, ext_irq_five_in)
        `CK("irq bit3", 1'b1, ext_irq_six_in)
        `CK("p1 read", 8'hba, p1_read_q & 8'hbf)
        first_port_latch = 8'he0; p1_low = 8'h00;
        verify_mode = 1; verify_addr_low = 8'h1f; step(5);
        `CK("gated", 5'h00, capture_in)
        `CK("gated irq", 1'b0, ext_irq_two_in)
        `CK("pin high", 8'h1f, p1_read_q)
        verify_mode = 0;
    endtask
    // Port two: latch drive, address on fetch and wide access, latch on short access
    task automatic t_p2();
        second_port_latch = 8'h3c; step(1);
        `CK("p2 weak", 8'h3c, p2_pin_oe_n)
        ext_prog_fetch = 1; addr_high = 8'ha5; p2_low = 8'hff; step(1);
        `CK("fetch", 8'ha5, p2_pin_in)
        `CK("strong", 8'ha5, p2_strong_up)
        ext_prog_fetch = 0; ext_data_wide_pointer_access = 1; addr_high = 8'h5a; step(1);
        `CK("wide", 8'h5a, p2_pin_in)
        ext_data_wide_pointer_access = 0; ext_data_short_pointer_access = 1; p2_low = 0; step(1);
        `CK("short", 8'h3c, p2_pin_in)
        `CK("released", 8'h00, p2_strong_up)
        step(3);
        `CK("p2 read", 8'h3c, p2_read_q)
        ext_data_short_pointer_access = 0;
    endtask
    // Divided clock phase and the bit 6 clock output each flip across one edge
    task automatic t_clk();
        logic ph, co;
        ph = clk_phase_q; co = p1_pin_out[6]; step(1);
        `CK("phase", ~ph, clk_phase_q)
        `CK("clock out", ~co, p1_pin_out[6])
    endtask
    // Counts, then the verdict
    task automatic complete_run();
        $display("comparisons %0d mismatches %0d", cmp_count, err_total);
        if (err_total == 0 && cmp_count > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask
    // Two reset cycles, then the scenarios
    initial begin
        step(2); rst = 0;
        t_p1(); t_p2(); t_clk(); complete_run();
    end
endmodule // qbp_ports_tb
bind qbp_ports qbp_ports_props #(.W(W)) qbp_ports_props_inst (.*);
`default_nettype wire
